// >>> rtl/pscm_pkg.sv
package pscm_pkg;

  // Register byte offsets on the APB bus
  localparam logic [11:0] OFS_IDENTITY = 12'h000;
  localparam logic [11:0] OFS_EXT_PTR = 12'h004;
  localparam logic [11:0] OFS_LAT_IRQ = 12'h008;
  localparam logic [11:0] OFS_TGT_CTL = 12'h00c;

  // Field positions
  localparam int unsigned ID_DEVICE_LSB = 16;
  localparam int unsigned ID_MAKER_LSB = 0;
  localparam int unsigned LAT_INTERVAL_LSB = 24;
  localparam int unsigned LAT_BURST_LSB = 16;
  localparam int unsigned LAT_PIN_LSB = 8;
  localparam int unsigned LAT_ROUTE_LSB = 0;
  localparam int unsigned CTL_WIN_LSB = 16;
  localparam int unsigned CTL_RETRY_MULT_BIT = 4;
  localparam int unsigned CTL_RETRY_LINE_BIT = 3;
  localparam int unsigned CTL_RETRY_PLAIN_BIT = 2;
  localparam int unsigned CTL_TIMEOUT_DIS_BIT = 1;
  localparam int unsigned CTL_LOADED_BIT = 0;

  // Constant and reset values
  localparam logic [7:0] EXT_ENTRY_OFFSET = 8'h40;
  localparam logic [7:0] INT_PIN_VALUE = 8'h01;
  localparam logic [15:0] ID_FIELD_RST = 16'h0000;
  localparam logic [7:0] LAT_FIELD_RST = 8'h00;
  localparam logic [5:0] WIN_EN_RST = 6'h00;
  localparam logic CTL_BIT_RST = 1'b0;

  // Timing
  localparam int unsigned TIMEOUT_CYCLES = 16;
  localparam int unsigned NUM_WINDOWS = 6;

  typedef enum logic [2:0] {
    CMD_MEM_READ,
    CMD_MEM_READ_LINE,
    CMD_MEM_READ_MULT,
    CMD_MEM_WRITE,
    CMD_CFG_READ,
    CMD_CFG_WRITE
  } pscm_cmd_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } pscm_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pscm_apb_rsp_t;

  typedef struct packed {
    logic valid;
    pscm_cmd_t cmd;
    logic bar_access;
    logic [5:0] window_hit;
    logic [31:0] addr;
  } pscm_tgt_req_t;

  typedef struct packed {
    logic ignore;
    logic retry;
    logic done;
    logic waiting;
    logic bar_write;
  } pscm_tgt_rsp_t;

  typedef struct packed {
    logic valid;
    pscm_cmd_t cmd;
    logic [31:0] addr;
  } pscm_fetch_req_t;

  function automatic logic [31:0] pscm_merge(input logic [31:0] old_word, input logic [31:0] new_word,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic pscm_is_mem_read(input pscm_cmd_t cmd);
    return (cmd == CMD_MEM_READ) || (cmd == CMD_MEM_READ_LINE) || (cmd == CMD_MEM_READ_MULT);
  endfunction

endpackage

// >>> rtl/pscm_top.sv
// Behaviour
// RULE1 - A read-only word holds the board device identifier in bits 31-16 and board maker identifier in 15-0, both zero after reset.
// RULE2 - The extension list pointer reads 40h in bits 7-0 and zero above.
// RULE3 - A writable 8-bit bus access interval in bits 31-24, in quarter microsecond units, resets to zero.
// RULE4 - A writable 8-bit burst length request in bits 23-16, in quarter microsecond units, resets to zero.
// RULE5 - Bits 15-8 of the latency word read a fixed 01h naming interrupt line A.
// RULE6 - The host writes the interrupt controller input number into bits 7-0, which is stored, returned unchanged, and reset to zero.
// RULE7 - When a window enable bit in 21-16 is zero, host accesses aimed at that window are ignored.
// RULE8 - Host writes to the base address registers are accepted whatever the window enables say.
// RULE9 - With bit 4 clear, Memory Read Multiple uses the normal 16-cycle timeout and retries if data is late.
// RULE10 - With bit 4 set, every decoded Memory Read Multiple is retried at once, over the timeout disable; a repeat of a fetched delayed read completes.
// RULE11 - With timeout disable set and no forced retry, wait states go on until the access can complete.
// RULE12 - While the loaded bit is zero all PCI accesses are refused; it resets to zero.
// RULE13 - A forced retry bit retries every plain Memory Read at once, else the 16-cycle timeout applies; a repeat of a fetched delayed read completes instead.
// RULE14 - A forced retry bit retries every Memory Read Line at once, else the 16-cycle timeout applies; a repeat of a fetched delayed read completes instead.
// RULE15 - A retried read is latched as a delayed request and prefetched, and the repeated identical read completes; code latches only into an empty slot.
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module pscm_top #(
  parameter int unsigned TIMEOUT = pscm_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // APB register port
  input wire pscm_pkg::pscm_apb_req_t apb_req_in,
  output pscm_pkg::pscm_apb_rsp_t apb_rsp_out,
  // Identity load from the boot loader side
  input wire logic id_load_in,
  input wire logic [31:0] id_value_in,
  // Decoded target request from the PCI core
  input wire pscm_pkg::pscm_tgt_req_t tgt_req_in,
  input wire logic data_ready_in,
  output pscm_pkg::pscm_tgt_rsp_t tgt_rsp_out,
  // Delayed read prefetch to the back end
  output pscm_pkg::pscm_fetch_req_t fetch_req_out,
  input wire logic fetch_done_in
);
  import pscm_pkg::*;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_WAIT
  } pscm_state_t;

  initial begin
    if (TIMEOUT < 2) begin
      $error("pscm_top: TIMEOUT must be at least 2");
    end
  end

  // Register state
  logic [15:0] device_id;
  logic [15:0] maker_id;
  logic [7:0] bus_access_interval;
  logic [7:0] burst_length_request;
  logic [7:0] irq_route;
  logic [5:0] window_enable;
  logic retry_all_read_multiple;
  logic retry_all_read_line;
  logic retry_all_plain_read;
  logic target_timeout_disable;
  logic config_loaded;

  // APB decode
  logic apb_setup;
  logic apb_access;
  logic apb_wr;
  logic addr_known;
  logic [31:0] read_word;
  logic [31:0] lat_word;
  logic [31:0] ctl_word;
  logic [31:0] lat_next;
  logic [31:0] ctl_next;
  logic [31:0] rd_data;
  logic rd_err;

  assign apb_setup = apb_req_in.psel && !apb_req_in.penable;
  assign apb_access = apb_req_in.psel && apb_req_in.penable;
  assign apb_wr = apb_access && apb_req_in.pwrite;
  assign addr_known = (apb_req_in.paddr == OFS_IDENTITY) || (apb_req_in.paddr == OFS_EXT_PTR) ||
                      (apb_req_in.paddr == OFS_LAT_IRQ) || (apb_req_in.paddr == OFS_TGT_CTL);

  always_comb begin
    lat_word = '0;
    lat_word[LAT_INTERVAL_LSB +: 8] = bus_access_interval;
    lat_word[LAT_BURST_LSB +: 8] = burst_length_request;
    lat_word[LAT_PIN_LSB +: 8] = INT_PIN_VALUE; // [RULE5]
    lat_word[LAT_ROUTE_LSB +: 8] = irq_route;
  end

  always_comb begin
    ctl_word = '0;
    ctl_word[CTL_WIN_LSB +: NUM_WINDOWS] = window_enable;
    ctl_word[CTL_RETRY_MULT_BIT] = retry_all_read_multiple;
    ctl_word[CTL_RETRY_LINE_BIT] = retry_all_read_line;
    ctl_word[CTL_RETRY_PLAIN_BIT] = retry_all_plain_read;
    ctl_word[CTL_TIMEOUT_DIS_BIT] = target_timeout_disable;
    ctl_word[CTL_LOADED_BIT] = config_loaded;
  end

  assign lat_next = pscm_merge(lat_word, apb_req_in.pwdata, apb_req_in.pstrb);
  assign ctl_next = pscm_merge(ctl_word, apb_req_in.pwdata, apb_req_in.pstrb);

  always_comb begin
    read_word = '0;
    case (apb_req_in.paddr)
      OFS_IDENTITY: begin
        read_word[ID_DEVICE_LSB +: 16] = device_id; // [RULE1]
        read_word[ID_MAKER_LSB +: 16] = maker_id;
      end
      OFS_EXT_PTR: begin
        read_word[7:0] = EXT_ENTRY_OFFSET; // [RULE2]
      end
      OFS_LAT_IRQ: begin
        read_word = lat_word;
      end
      OFS_TGT_CTL: begin
        read_word = ctl_word;
      end
      default: begin
        read_word = '0;
      end
    endcase
  end

  // Read data and error are settled in the setup cycle so they come from flops
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data <= '0;
      rd_err <= 1'b0;
    end else if (apb_setup) begin
      rd_data <= apb_req_in.pwrite ? 32'h0000_0000 : read_word;
      rd_err <= !addr_known;
    end
  end

  // Zero wait states: the access phase always ends in one cycle
  assign apb_rsp_out = {rd_data, apb_access, rd_err};

  // Identity is read-only to software; only the loader path fills it
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      device_id <= ID_FIELD_RST; // [RULE1]
      maker_id <= ID_FIELD_RST;
    end else if (id_load_in) begin
      device_id <= id_value_in[ID_DEVICE_LSB +: 16];
      maker_id <= id_value_in[ID_MAKER_LSB +: 16];
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_access_interval <= LAT_FIELD_RST;
      burst_length_request <= LAT_FIELD_RST;
      irq_route <= LAT_FIELD_RST;
    end else if (apb_wr && apb_req_in.paddr == OFS_LAT_IRQ) begin
      bus_access_interval <= lat_next[LAT_INTERVAL_LSB +: 8]; // [RULE3]
      burst_length_request <= lat_next[LAT_BURST_LSB +: 8]; // [RULE4]
      irq_route <= lat_next[LAT_ROUTE_LSB +: 8]; // [RULE6]
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      window_enable <= WIN_EN_RST;
      retry_all_read_multiple <= CTL_BIT_RST;
      retry_all_read_line <= CTL_BIT_RST;
      retry_all_plain_read <= CTL_BIT_RST;
      target_timeout_disable <= CTL_BIT_RST;
      config_loaded <= CTL_BIT_RST; // [RULE12]
    end else if (apb_wr && apb_req_in.paddr == OFS_TGT_CTL) begin
      window_enable <= ctl_next[CTL_WIN_LSB +: NUM_WINDOWS];
      retry_all_read_multiple <= ctl_next[CTL_RETRY_MULT_BIT];
      retry_all_read_line <= ctl_next[CTL_RETRY_LINE_BIT];
      retry_all_plain_read <= ctl_next[CTL_RETRY_PLAIN_BIT];
      target_timeout_disable <= ctl_next[CTL_TIMEOUT_DIS_BIT];
      config_loaded <= ctl_next[CTL_LOADED_BIT];
    end
  end

  // Target response engine
  pscm_state_t state;
  pscm_state_t next_state;
  logic timer_expired;
  logic is_read;
  logic forced_retry;
  logic window_off;
  logic dly_valid;
  logic dly_fetched;
  pscm_cmd_t dly_cmd;
  logic [31:0] dly_addr;
  logic dly_match;
  logic latch_dly;
  logic [$clog2(TIMEOUT + 1)-1:0] wait_cycles;

  assign is_read = pscm_is_mem_read(tgt_req_in.cmd);
  assign window_off = !tgt_req_in.bar_access && ((tgt_req_in.window_hit & window_enable) == 6'h00);
  assign dly_match = dly_valid && dly_cmd == tgt_req_in.cmd && dly_addr == tgt_req_in.addr;

  always_comb begin
    case (tgt_req_in.cmd)
      CMD_MEM_READ_MULT: forced_retry = retry_all_read_multiple; // [RULE9] [RULE10]
      CMD_MEM_READ_LINE: forced_retry = retry_all_read_line; // [RULE14]
      CMD_MEM_READ: forced_retry = retry_all_plain_read; // [RULE13]
      default: forced_retry = 1'b0;
    endcase
  end

  pscm_wait_timer #(
    .LIMIT(TIMEOUT)
  ) u_wait_timer (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .run_in(state == ST_WAIT),
    .expired_out(timer_expired)
  );

  always_comb begin
    next_state = state;
    tgt_rsp_out = '0;
    latch_dly = 1'b0;
    case (state)
      ST_IDLE: begin
        if (tgt_req_in.valid) begin
          if (!config_loaded) begin
            tgt_rsp_out.ignore = 1'b1; // [RULE12]
          end else if (tgt_req_in.bar_access) begin
            tgt_rsp_out.done = 1'b1;
            tgt_rsp_out.bar_write = (tgt_req_in.cmd == CMD_CFG_WRITE); // [RULE8]
          end else if (window_off) begin
            tgt_rsp_out.ignore = 1'b1; // [RULE7]
          end else if (is_read && dly_match && dly_fetched) begin
            tgt_rsp_out.done = 1'b1; // [RULE15]
          end else if (is_read && (forced_retry || dly_match)) begin
            // A pending prefetch for the same read is retried, never re-queued
            tgt_rsp_out.retry = 1'b1; // [RULE10] [RULE13] [RULE14]
            latch_dly = !dly_valid;
          end else if (data_ready_in) begin
            tgt_rsp_out.done = 1'b1;
          end else begin
            tgt_rsp_out.waiting = 1'b1;
            next_state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        tgt_rsp_out.waiting = 1'b1;
        if (data_ready_in) begin
          tgt_rsp_out.waiting = 1'b0;
          tgt_rsp_out.done = 1'b1;
          next_state = ST_IDLE;
        end else if (timer_expired && !target_timeout_disable) begin // [RULE11]
          tgt_rsp_out.waiting = 1'b0;
          tgt_rsp_out.retry = 1'b1; // [RULE9] [RULE13] [RULE14]
          latch_dly = is_read && !dly_valid; // [RULE15]
          next_state = ST_IDLE;
        end
        // With the timeout disabled the wait simply holds [RULE11]
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Checker-side count of wait cycles, kept apart from the timer it checks
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_cycles <= '0;
    end else if (state != ST_WAIT) begin
      wait_cycles <= '0;
    end else if (!(&wait_cycles)) begin
      wait_cycles <= wait_cycles + 1'b1;
    end
  end

  // One delayed read slot; while it is full no other retried read is latched
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dly_valid <= 1'b0;
      dly_fetched <= 1'b0;
      dly_cmd <= CMD_MEM_READ;
      dly_addr <= '0;
    end else if (latch_dly) begin
      dly_valid <= 1'b1; // [RULE15]
      dly_fetched <= 1'b0;
      dly_cmd <= tgt_req_in.cmd;
      dly_addr <= tgt_req_in.addr;
    end else if (state == ST_IDLE && tgt_rsp_out.done && dly_match) begin
      dly_valid <= 1'b0;
      dly_fetched <= 1'b0;
    end else if (dly_valid && fetch_done_in) begin
      dly_fetched <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fetch_req_out <= '0;
    end else begin
      fetch_req_out.valid <= latch_dly; // [RULE15]
      if (latch_dly) begin
        fetch_req_out.cmd <= tgt_req_in.cmd;
        fetch_req_out.addr <= tgt_req_in.addr;
      end
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  chk_ident_readonly: assert property ((apb_wr && apb_req_in.paddr == OFS_IDENTITY && !id_load_in) // [RULE1]
    |=> $stable(device_id) && $stable(maker_id)) else $error("identity changed by a bus write");

  chk_ext_ptr_value: assert property ((apb_setup && !apb_req_in.pwrite && apb_req_in.paddr == OFS_EXT_PTR) // [RULE2]
    |=> apb_rsp_out.prdata == 32'h0000_0040) else $error("extension pointer not 40h");

  chk_interval_write: assert property ((apb_wr && apb_req_in.paddr == OFS_LAT_IRQ && apb_req_in.pstrb[3]) // [RULE3]
    |=> bus_access_interval == $past(apb_req_in.pwdata[31:24])) else $error("interval not stored");

  chk_burst_write: assert property ((apb_wr && apb_req_in.paddr == OFS_LAT_IRQ && apb_req_in.pstrb[2]) // [RULE4]
    |=> burst_length_request == $past(apb_req_in.pwdata[23:16])) else $error("burst length not stored");

  chk_int_pin_fixed: assert property ((apb_setup && !apb_req_in.pwrite && apb_req_in.paddr == OFS_LAT_IRQ) // [RULE5]
    |=> apb_rsp_out.prdata[15:8] == 8'h01) else $error("interrupt pin field not 01h");

  chk_route_roundtrip: assert property ((apb_wr && apb_req_in.paddr == OFS_LAT_IRQ && apb_req_in.pstrb[0]) // [RULE6]
    ##2 (apb_setup && !apb_req_in.pwrite && apb_req_in.paddr == OFS_LAT_IRQ)
    |=> apb_rsp_out.prdata[7:0] == $past(apb_req_in.pwdata[7:0], 3)) else $error("route value not returned");

  chk_window_ignore: assert property ((state == ST_IDLE && tgt_req_in.valid && window_off) // [RULE7]
    |-> tgt_rsp_out.ignore && !tgt_rsp_out.done) else $error("disabled window access not ignored");

  chk_bar_write_pass: assert property ((state == ST_IDLE && tgt_req_in.valid && config_loaded && tgt_req_in.bar_access
    && tgt_req_in.cmd == CMD_CFG_WRITE) |-> tgt_rsp_out.bar_write) else $error("base address write dropped"); // [RULE8]

  chk_timeout_retry: assert property ((state == ST_WAIT && !target_timeout_disable && !data_ready_in) // [RULE9]
    |-> tgt_rsp_out.retry == (wait_cycles == TIMEOUT - 1)) else $error("retry not at the timeout cycle");

  chk_mult_forced: assert property ((state == ST_IDLE && tgt_req_in.valid && config_loaded && !window_off // [RULE10]
    && !tgt_req_in.bar_access && tgt_req_in.cmd == CMD_MEM_READ_MULT && retry_all_read_multiple && !dly_fetched)
    |-> tgt_rsp_out.retry) else $error("read multiple not retried at once");

  chk_no_timeout: assert property ((state == ST_WAIT && target_timeout_disable && !data_ready_in) // [RULE11]
    |-> !tgt_rsp_out.retry && tgt_rsp_out.waiting ##1 state == ST_WAIT) else $error("wait ended without data");

  chk_refuse_unloaded: assert property ((tgt_req_in.valid && !config_loaded && state == ST_IDLE) // [RULE12]
    |-> tgt_rsp_out.ignore && !tgt_rsp_out.done && !tgt_rsp_out.retry) else $error("access while not loaded");

  chk_plain_forced: assert property ((state == ST_IDLE && tgt_req_in.valid && config_loaded && !window_off // [RULE13]
    && !tgt_req_in.bar_access && tgt_req_in.cmd == CMD_MEM_READ && retry_all_plain_read && !dly_fetched)
    |-> tgt_rsp_out.retry) else $error("plain read not retried at once");

  chk_line_forced: assert property ((state == ST_IDLE && tgt_req_in.valid && config_loaded && !window_off // [RULE14]
    && !tgt_req_in.bar_access && tgt_req_in.cmd == CMD_MEM_READ_LINE && retry_all_read_line && !dly_fetched)
    |-> tgt_rsp_out.retry) else $error("read line not retried at once");

  chk_delayed_latch: assert property ((tgt_rsp_out.retry && is_read && !dly_valid) // [RULE15]
    |=> dly_valid && fetch_req_out.valid && dly_addr == $past(tgt_req_in.addr)) else $error("retried read not latched");

endmodule

// >>> rtl/pscm_wait_timer.sv
`timescale 1ns/100ps
module pscm_wait_timer #(
  parameter int unsigned LIMIT = 16
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Control
  input wire logic run_in,
  // Status
  output logic expired_out
);
  localparam int unsigned CW = $clog2(LIMIT + 1);

  logic [CW-1:0] count;

  initial begin
    if (LIMIT < 2) begin
      $error("pscm_wait_timer: LIMIT must be at least 2");
    end
  end

  // Counts wait cycles of the current access; drops back when idle
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count <= '0;
    end else if (!run_in) begin
      count <= '0;
    end else if (count != CW'(LIMIT)) begin
      count <= count + CW'(1);
    end
  end

  assign expired_out = run_in && (count == CW'(LIMIT - 1));

endmodule

// >>> testbench/pscm_pci_master.sv
`timescale 1ns/100ps
module pscm_pci_master #(
  parameter int unsigned FETCH_LAT = 3
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Bench control
  input wire logic start_in,
  input wire pscm_pkg::pscm_tgt_req_t req_in,
  output logic busy_out,
  output logic [1:0] result_out,
  output logic [7:0] cycles_out,
  // Target side of the block
  input wire pscm_pkg::pscm_tgt_rsp_t rsp_in,
  output pscm_pkg::pscm_tgt_req_t req_out,
  // Back end prefetch
  input wire pscm_pkg::pscm_fetch_req_t fetch_in,
  output logic fetch_done_out
);
  import pscm_pkg::*;
  logic [3:0] fetch_cnt;

  // Valid held until a response; released address is scrambled so stale values never match
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      req_out <= '0;
      busy_out <= 1'b0;
      result_out <= 2'h0;
      cycles_out <= 8'h00;
    end else if (start_in && !busy_out) begin
      req_out <= req_in;
      req_out.valid <= 1'b1;
      busy_out <= 1'b1;
      cycles_out <= 8'h00;
    end else if (busy_out) begin
      if (rsp_in.ignore || rsp_in.retry || rsp_in.done) begin
        result_out <= rsp_in.done ? (rsp_in.bar_write ? 2'h3 : 2'h2) : {1'b0, rsp_in.retry};
        req_out.valid <= 1'b0;
        req_out.addr <= ~req_out.addr;
        busy_out <= 1'b0;
      end else begin
        cycles_out <= cycles_out + 8'h01;
      end
    end
  end

  // Prefetch answered after a fixed latency
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fetch_cnt <= 4'h0;
      fetch_done_out <= 1'b0;
    end else begin
      fetch_done_out <= (fetch_cnt == 4'h1);
      if (fetch_in.valid) begin
        fetch_cnt <= FETCH_LAT[3:0];
      end else if (fetch_cnt != 4'h0) begin
        fetch_cnt <= fetch_cnt - 4'h1;
      end
    end
  end
endmodule

// >>> testbench/tb.sv
`timescale 1ns/100ps
module tb;
  import pscm_pkg::*;
  // Short timeout keeps the read loops brief
  localparam int unsigned TO = 4;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  pscm_apb_req_t apb_req = '0;
  pscm_apb_rsp_t apb_rsp;
  logic id_load = 1'b0;
  logic [31:0] id_value = 32'h0;
  pscm_tgt_req_t tgt_req;
  pscm_tgt_req_t m_req = '0;
  pscm_tgt_rsp_t tgt_rsp;
  pscm_fetch_req_t fetch_req;
  logic fetch_done;
  logic data_ready = 1'b0;
  logic m_start = 1'b0;
  logic m_busy;
  logic [1:0] m_res;
  logic [7:0] m_cyc;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int rdy_after = 0;

  pscm_top #(.TIMEOUT(TO)) dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .apb_req_in(apb_req),
    .apb_rsp_out(apb_rsp), .id_load_in(id_load), .id_value_in(id_value), .tgt_req_in(tgt_req),
    .data_ready_in(data_ready), .tgt_rsp_out(tgt_rsp), .fetch_req_out(fetch_req), .fetch_done_in(fetch_done));
  pscm_pci_master pm (.core_clk_in(core_clk_in), .rst_in(rst_in), .start_in(m_start), .req_in(m_req),
    .busy_out(m_busy), .result_out(m_res), .cycles_out(m_cyc), .rsp_in(tgt_rsp), .req_out(tgt_req),
    .fetch_in(fetch_req), .fetch_done_out(fetch_done));

  always #5 core_clk_in = ~core_clk_in;

  // Back end readiness: 0 means always ready, else after that many wait cycles
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    data_ready <= (rdy_after == 0) || (m_busy && m_cyc >= rdy_after);
    if (cyc == 20000) begin
      errors = errors + 1;
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic do_reset();
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk_in);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= a;
    apb_req.pwdata <= wd;
    apb_req.pstrb <= 4'hf;
    @(posedge core_clk_in);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    check("pready", {31'h0, apb_rsp.pready}, 32'h1);
  endtask

  // One target transfer; cy below zero skips the wait-cycle compare
  task automatic run(input pscm_cmd_t c, input logic bar, input logic [5:0] w, input logic [31:0] a,
                     input logic [1:0] r, input int cy);
    int n;
    n = 0;
    @(posedge core_clk_in);
    m_req.cmd <= c;
    m_req.bar_access <= bar;
    m_req.window_hit <= w;
    m_req.addr <= a;
    m_start <= 1'b1;
    @(posedge core_clk_in);
    m_start <= 1'b0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (m_busy !== 1'b0 && n < 100);
    check("response code", {30'h0, m_res}, {30'h0, r});
    if (cy >= 0) begin
      check("wait cycles", {24'h0, m_cyc}, cy);
    end
  endtask

  task automatic t_reset();
    apb(1'b0, OFS_IDENTITY, 32'h0);
    check("identity", rd, 32'h0);
    apb(1'b0, OFS_EXT_PTR, 32'h0);
    check("ext pointer", rd, 32'h0000_0040);
    apb(1'b0, OFS_LAT_IRQ, 32'h0);
    check("latency", rd, 32'h0000_0100);
    apb(1'b0, OFS_TGT_CTL, 32'h0);
    check("control", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    rdy_after = 0;
    run(CMD_MEM_WRITE, 1'b0, 6'h01, 32'h20, 2'h0, 0);
    $display("t_reset done");
  endtask

  task automatic t_regs();
    apb(1'b1, OFS_LAT_IRQ, 32'hffff_ffff);
    apb(1'b0, OFS_LAT_IRQ, 32'h0);
    check("latency ones", rd, 32'hffff_01ff);
    apb(1'b1, OFS_LAT_IRQ, 32'h1234_5678);
    apb(1'b0, OFS_LAT_IRQ, 32'h0);
    check("latency mix", rd, 32'h1234_0178);
    apb(1'b1, OFS_EXT_PTR, 32'hffff_ffff);
    apb(1'b0, OFS_EXT_PTR, 32'h0);
    check("ext pointer ro", rd, 32'h0000_0040);
    apb(1'b1, OFS_IDENTITY, 32'hffff_ffff);
    apb(1'b0, OFS_IDENTITY, 32'h0);
    check("identity ro", rd, 32'h0);
    @(posedge core_clk_in);
    id_load <= 1'b1;
    id_value <= 32'hbeef_cafe;
    @(posedge core_clk_in);
    id_load <= 1'b0;
    apb(1'b0, OFS_IDENTITY, 32'h0);
    check("identity loaded", rd, 32'hbeef_cafe);
    apb(1'b1, OFS_TGT_CTL, 32'hffff_ffff);
    apb(1'b0, OFS_TGT_CTL, 32'h0);
    check("control ones", rd, 32'h003f_001f);
    $display("t_regs done");
  endtask

  task automatic t_windows();
    logic [5:0] other;
    rdy_after = 0;
    apb(1'b1, OFS_TGT_CTL, 32'h003f_0000);
    run(CMD_MEM_WRITE, 1'b0, 6'h01, 32'h40, 2'h0, 0);
    for (int i = 0; i < 6; i++) begin
      other = 6'h01 << ((i + 1) % 6);
      apb(1'b1, OFS_TGT_CTL, 32'h1 | (32'h1 << (16 + i)));
      run(CMD_MEM_WRITE, 1'b0, 6'h01 << i, 32'h80, 2'h2, 0);
      run(CMD_MEM_WRITE, 1'b0, other, 32'h80, 2'h0, 0);
      run(CMD_CFG_WRITE, 1'b1, other, 32'h10, 2'h3, 0);
    end
    $display("t_windows done");
  endtask

  task automatic t_reads();
    logic [31:0] a;
    rdy_after = 255;
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 3; k++) begin
        a = 32'h1000 + 32'(k * 16 + f * 64);
        apb(1'b1, OFS_TGT_CTL, 32'h0001_0001 | (f != 0 ? (32'h2 | (32'h1 << (2 + k))) : 32'h0));
        run(pscm_cmd_t'(k), 1'b0, 6'h01, a, 2'h1, f != 0 ? 0 : TO);
        for (int n = 0; n < 50 && fetch_done !== 1'b1; n++) begin
          @(posedge core_clk_in);
        end
        check("fetch addr", fetch_req.addr, a);
        check("fetch cmd", {29'h0, fetch_req.cmd}, k);
        run(pscm_cmd_t'(k), 1'b0, 6'h01, a, 2'h2, 0);
      end
    end
    $display("t_reads done");
  endtask

  task automatic t_wait();
    rdy_after = 3 * TO;
    apb(1'b1, OFS_TGT_CTL, 32'h0001_0003);
    run(CMD_MEM_WRITE, 1'b0, 6'h01, 32'h200, 2'h2, -1);
    check("long wait", {31'h0, m_cyc >= 3 * TO}, 32'h1);
    rdy_after = 0;
    $display("t_wait done");
  endtask

  initial begin
    do_reset();
    t_reset();
    t_regs();
    t_windows();
    t_reads();
    t_wait();
    do_reset();
    t_reset();
    test_done();
  end
endmodule
